// *** src/erl_pkg.sv ***
// Shared constants and types for the error report log block.
// Assumes a single node clock; all users reference names with erl_pkg::.
package erl_pkg;

    // Register offsets (byte addresses, one word each)
    localparam logic [7:0] OFS_LOG = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_CMD = 8'h08;

    // Command register fields
    localparam int CMD_INTERCHANGE_BIT = 0;

    // Reset values and count levels of the control fields of the log
    localparam logic [1:0] COUNT_RST = 2'h0;
    localparam logic [1:0] COUNT_MAX = 2'h3;
    localparam logic [1:0] COUNT_ONE = 2'h1;
    localparam logic [1:0] COUNT_TWO = 2'h2;
    localparam logic PERM_RST = 1'b0;

    // Error type codes, highest priority has the largest code
    typedef enum logic [3:0] {
        ET_TOGGLE = 4'h0,
        ET_DETACH = 4'h1,
        ET_ATTACH = 4'h2,
        ET_INTERCHANGE = 4'h3,
        ET_TEST = 4'h4,
        ET_CORR_ECC = 4'h5,
        ET_UNCORR_ECC = 4'h6,
        ET_BUS_MOD_LOW = 4'h7,
        ET_BUS_PARITY = 4'h8,
        ET_MODULE = 4'h9,
        ET_NO_ERROR = 4'hA,
        ET_BUS_MOD_HIGH = 4'hB,
        ET_ARBITRATION = 4'hC,
        ET_UNSAFE_MODULE = 4'hD,
        ET_MODULE_LINE = 4'hE,
        ET_BUS_LINE = 4'hF
    } erl_type_e;

    // One received error report, sampled on its completion cycle
    typedef struct packed {
        logic [3:0] err_type;
        logic [8:0] node_id;
        logic permanent;
    } erl_report_s;

    // The 16-bit log word, most significant field first
    typedef struct packed {
        logic permanent;
        logic [1:0] count;
        logic [3:0] err_type;
        logic [8:0] node_id;
    } erl_log_s;

    // Recovery decisions drawn from the latest logged report
    typedef struct packed {
        logic fault_bus;
        logic fault_module;
        logic dealloc_bus;
        logic dealloc_module;
        logic kill_module;
        logic switch_inhibit;
    } erl_action_s;

    localparam erl_action_s ACTION_NONE = '0;

endpackage

// *** src/erl_error_report_log.sv ***
// Error report log of one interconnect node, with recovery decode.
// Assumes reports arrive from same-clock reporting logic as one-cycle
// completion pulses, and software uses the plain register port.

`timescale 1ns/1ps
`default_nettype none

module erl_error_report_log #(
    parameter int ADDR_W = 8,
    parameter int DATA_W = 32
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // Report from the error reporting network
    input wire logic net_report_valid,
    input wire erl_pkg::erl_report_s net_report,
    // Report detected by this node itself
    input wire logic local_report_valid,
    input wire erl_pkg::erl_report_s local_report,
    input wire logic node_isolated,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    // Request to broadcast an interchange command
    output logic interchange_req,
    // Recovery decisions and their one-cycle strobe
    output erl_pkg::erl_action_s action,
    output logic action_valid,
    // Whole log word for recovery and observation
    output erl_pkg::erl_log_s log_word
);

    // Priority of one type over another: the code itself is the rank
    function automatic logic ranks_above(
        input logic [3:0] a,
        input logic [3:0] b
    );
        ranks_above = (a > b);
    endfunction

    // True when the log holds one error, or two with permanent set and a type other than unsafe module
    function automatic logic single_error(
        input erl_pkg::erl_log_s lw
    );
        logic res;
        res = 1'b0;
        case (lw.count)
            erl_pkg::COUNT_ONE: begin
                res = 1'b1;
            end
            erl_pkg::COUNT_TWO: begin
                res = lw.permanent &&
                    (lw.err_type != erl_pkg::ET_UNSAFE_MODULE);
            end
            default: begin
                res = 1'b0;
            end
        endcase
        single_error = res;
    endfunction

    // Recovery decision for one error type
    function automatic erl_pkg::erl_action_s decide(
        input logic [3:0] t
    );
        erl_pkg::erl_action_s a;
        a = erl_pkg::ACTION_NONE;
        case (t)
            erl_pkg::ET_BUS_LINE,
            erl_pkg::ET_ARBITRATION,
            erl_pkg::ET_BUS_PARITY,
            erl_pkg::ET_DETACH: begin
                a.fault_bus = 1'b1;
                a.dealloc_bus = 1'b1;
            end
            erl_pkg::ET_MODULE_LINE,
            erl_pkg::ET_MODULE,
            erl_pkg::ET_UNCORR_ECC: begin
                a.fault_module = 1'b1;
                a.dealloc_module = 1'b1;
            end
            erl_pkg::ET_UNSAFE_MODULE: begin
                a.fault_module = 1'b1;
                a.dealloc_module = 1'b1;
                a.kill_module = 1'b1;
                a.switch_inhibit = 1'b1;
            end
            erl_pkg::ET_BUS_MOD_HIGH: begin
                // Interface fault: both areas faulty, unit must not switch
                a.fault_bus = 1'b1;
                a.fault_module = 1'b1;
                a.dealloc_module = 1'b1;
                a.switch_inhibit = 1'b1;
            end
            erl_pkg::ET_BUS_MOD_LOW: begin
                // Either area would isolate it; keep the bus
                a.fault_bus = 1'b1;
                a.fault_module = 1'b1;
                a.dealloc_module = 1'b1;
            end
            default: begin
                a = erl_pkg::ACTION_NONE;
            end
        endcase
        decide = a;
    endfunction

    // Register decode
    logic sel_log;
    logic sel_status;
    logic sel_cmd;

    assign sel_log = (reg_addr == erl_pkg::OFS_LOG);
    assign sel_status = (reg_addr == erl_pkg::OFS_STATUS);
    assign sel_cmd = (reg_addr == erl_pkg::OFS_CMD);

    // Report source: a broken node only sees its own detections
    logic rpt_valid;
    erl_pkg::erl_report_s rpt;

    always_comb begin
        if (node_isolated) begin
            rpt_valid = local_report_valid;
            rpt = local_report;
        end else begin
            rpt_valid = net_report_valid;
            rpt = net_report;
        end
    end

    // Next log word, built whole before the single update
    erl_pkg::erl_log_s next_log;
    logic is_interchange;

    assign is_interchange = (rpt.err_type == erl_pkg::ET_INTERCHANGE);

    always_comb begin
        next_log = log_word;
        // Latest report overwrites type and node
        next_log.err_type = rpt.err_type;
        next_log.node_id = rpt.node_id;
        if (is_interchange) begin
            next_log.count = erl_pkg::COUNT_RST;
            next_log.permanent = 1'b1;
        end else begin
            if (log_word.count != erl_pkg::COUNT_MAX) begin
                next_log.count = log_word.count + erl_pkg::COUNT_ONE;
            end else begin
                next_log.count = erl_pkg::COUNT_MAX;
            end
            next_log.permanent = log_word.permanent | rpt.permanent;
        end
    end

    // Whole log word in one process so no field has a second driver;
    // reset clears only the control fields, crash data stays readable
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            log_word.count <= erl_pkg::COUNT_RST;
            log_word.permanent <= erl_pkg::PERM_RST;
        end else if (ce && rpt_valid) begin
            log_word <= next_log;
        end
    end

    // Highest-ranked type seen since the last interchange
    logic [3:0] worst_type;
    logic worst_valid;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            worst_type <= erl_pkg::ET_TOGGLE;
            worst_valid <= 1'b0;
        end else if (ce && rpt_valid) begin
            if (is_interchange) begin
                worst_type <= erl_pkg::ET_TOGGLE;
                worst_valid <= 1'b0;
            end else if (!worst_valid || ranks_above(rpt.err_type, worst_type)) begin
                worst_type <= rpt.err_type;
                worst_valid <= 1'b1;
            end
        end
    end

    // Recovery decision for each report is registered on the same edge that logs it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            action <= erl_pkg::ACTION_NONE;
            action_valid <= 1'b0;
        end else if (ce) begin
            action_valid <= rpt_valid;
            if (rpt_valid) begin
                action <= decide(rpt.err_type);
            end
        end
    end

    // Interchange request: the only path by which software touches the log
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            interchange_req <= 1'b0;
        end else if (ce) begin
            interchange_req <= reg_wr && sel_cmd &&
                reg_wdata[erl_pkg::CMD_INTERCHANGE_BIT];
        end
    end

    // Status word: worst type, single-error flag, current decisions
    logic [DATA_W-1:0] status_word;

    always_comb begin
        status_word = '0;
        status_word[3:0] = worst_type;
        status_word[4] = worst_valid;
        status_word[5] = single_error(log_word);
        status_word[6] = (log_word.count == erl_pkg::COUNT_RST);
        status_word[12:7] = decide(log_word.err_type);
    end

    // Read data one cycle after the strobe; writes to the log are ignored
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else if (ce) begin
            if (reg_rd && sel_log) begin
                reg_rdata <= {{(DATA_W-16){1'b0}}, log_word};
            end else if (reg_rd && sel_status) begin
                reg_rdata <= status_word;
            end else begin
                reg_rdata <= '0;
            end
        end
    end

endmodule

`default_nettype wire

// *** verif/erl_partner.sv ***
// Stand-in for the other nodes that broadcast error reports.
// Assumes the node clock; a report leaves 1 to 4 cycles after go.
`timescale 1ns/1ps
`default_nettype none
module erl_partner (
    input wire logic clk,
    input wire logic go,
    input wire logic [1:0] dly,
    input wire erl_pkg::erl_report_s rep,
    output logic net_report_valid,
    output erl_pkg::erl_report_s net_report
);
    erl_pkg::erl_report_s held;
    logic [1:0] left;
    logic busy = 1'b0;
    initial net_report_valid = 1'b0;
    initial net_report = '0;
    // One pulse per request; idle lines toggle so stale data never looks valid
    always @(posedge clk) begin
        net_report_valid <= 1'b0;
        net_report <= ~net_report;
        if (go) begin
            held <= rep;
            left <= dly;
            busy <= 1'b1;
        end else if (busy) begin
            left <= left - 2'h1;
            if (left == 2'h0) begin
                net_report_valid <= 1'b1;
                net_report <= held;
                busy <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// *** verif/erl_log_asserts.sv ***
// Checker for the error report log, bound to the design top.
// Assumes one node clock and the synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module erl_log_asserts #(
    parameter int ADDR_W = 8,
    parameter int DATA_W = 32
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic net_report_valid,
    input wire erl_pkg::erl_report_s net_report,
    input wire logic local_report_valid,
    input wire logic node_isolated,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic interchange_req,
    input wire logic action_valid,
    input wire erl_pkg::erl_log_s log_word
);
    logic take;
    logic net;
    logic seen;
    // Report taken from the selected source; net marks a network one
    assign take = ce && (node_isolated ? local_report_valid : net_report_valid);
    assign net = take && !node_isolated;
    // Set once a report has filled the type and node fields
    always_ff @(posedge clk) seen <= seen | take;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    cnt_step_a: assert property (
        net && net_report.err_type != 4'h3 && log_word.count != 2'h3
        |=> log_word.count == $past(log_word.count) + 2'h1) else $error("count did not step");
    cnt_sat_a: assert property (
        net && net_report.err_type != 4'h3 && log_word.count == 2'h3
        |=> log_word.count == 2'h3) else $error("count left saturation");
    xchg_clear_a: assert property (
        net && net_report.err_type == 4'h3 |=> log_word.count == 2'h0 && log_word.permanent)
        else $error("interchange did not clear");
    field_copy_a: assert property (
        net |=> {log_word.err_type, log_word.node_id} == $past({net_report.err_type,
        net_report.node_id})) else $error("fields not copied");
    log_hold_a: assert property (
        seen && !take |=> $stable(log_word)) else $error("log changed without report");
    rd_word_a: assert property (
        ce && reg_rd && reg_addr == erl_pkg::OFS_LOG
        |=> reg_rdata == DATA_W'($past(log_word))) else $error("log read wrong");
    xchg_req_a: assert property (
        ce && reg_wr && reg_addr == erl_pkg::OFS_CMD && reg_wdata[0] |=> interchange_req)
        else $error("no interchange request");
    act_pulse_a: assert property (
        take |=> action_valid) else $error("no recovery strobe");
endmodule
bind erl_error_report_log erl_log_asserts #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_asserts (
    .clk(clk), .rst_n(rst_n), .ce(ce), .net_report_valid(net_report_valid),
    .net_report(net_report), .local_report_valid(local_report_valid),
    .node_isolated(node_isolated), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .interchange_req(interchange_req), .action_valid(action_valid), .log_word(log_word));
`default_nettype wire

// *** verif/tb_erl_error_report_log.sv ***
// Self-checking bench for the error report log with a network partner.
// Assumes package, design, partner and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module tb_erl_error_report_log;
    logic clk = 0, rst_n = 0, go = 0, iso = 0, lvalid = 0, reg_wr = 0, reg_rd = 0;
    logic nvalid, ireq, avalid;
    logic [1:0] dly = 0;
    logic [7:0] reg_addr = 0;
    logic [31:0] reg_wdata = 0, seed = 66, rdata;
    erl_pkg::erl_report_s rep = '0, lrep = '0, nrep;
    erl_pkg::erl_action_s act;
    erl_pkg::erl_log_s lw;
    int n_mismatch = 0, checks_done = 0, cyc = 0, mcnt = 0, mperm = 0, mtype = 0, mnode = 0;
    always #2 clk = ~clk;
    erl_partner u_net (.clk(clk), .go(go), .dly(dly), .rep(rep), .net_report_valid(nvalid),
        .net_report(nrep));
    erl_error_report_log u_dut (.clk(clk), .rst_n(rst_n), .ce(1'b1), .net_report_valid(nvalid),
        .net_report(nrep), .local_report_valid(lvalid), .local_report(lrep),
        .node_isolated(iso), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(rdata), .interchange_req(ireq), .action(act),
        .action_valid(avalid), .log_word(lw));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Expected recovery decision per type, bus/module/dealloc/kill/inhibit order
    function automatic logic [5:0] exp_act(input int t);
        case (t)
            15, 12, 8, 1: return 6'b10_1000;
            14, 9, 6: return 6'b01_0100;
            13: return 6'b01_0111;
            11: return 6'b11_0101;
            7: return 6'b11_0100;
            default: return 6'b00_0000;
        endcase
    endfunction
    // Reference log after one accepted report
    task automatic model(input int t, input int n, input int p);
        mcnt = (t == 3) ? 0 : ((mcnt == 3) ? 3 : mcnt + 1);
        mperm = (t == 3) ? 1 : (mperm | p);
        mtype = t;
        mnode = n;
    endtask
    // Partner sends one report; log compared once it arrives, action checked only if take
    task automatic send(input int t, input int n, input int p, input bit take);
        @(posedge clk);
        go <= 1'b1;
        dly <= 2'(rnd() % 4);
        rep <= {4'(t), 9'(n), p[0]};
        @(posedge clk);
        go <= 1'b0;
        for (int k = 0; k < 8 && !nvalid; k++) @(posedge clk);
        #1;
        if (take) begin
            model(t, n, p);
            `CHK(avalid, 1'b1)
            `CHK(act, exp_act(t))
        end
        `CHK(lw, {mperm[0], mcnt[1:0], mtype[3:0], mnode[8:0]})
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 `CHK(rdata, e)
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Cut a hang short
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        send(3, rnd() % 512, 0, 1);
        rd(erl_pkg::OFS_LOG, {16'h0000, mperm[0], mcnt[1:0], mtype[3:0], mnode[8:0]});
        wr(erl_pkg::OFS_LOG, rnd());
        wr(erl_pkg::OFS_STATUS, rnd());
        rd(erl_pkg::OFS_LOG, {16'h0000, mperm[0], mcnt[1:0], mtype[3:0], mnode[8:0]});
        rd(8'h40, 32'h0000_0000);
        rd(erl_pkg::OFS_STATUS, 32'h0000_0040);
        wr(erl_pkg::OFS_CMD, 32'h0000_0001);
        `CHK(ireq, 1'b1)
        $display("test register_port done");
        for (int i = 0; i < 40; i++) send(i % 16, rnd() % 512, rnd() % 4 == 0, 1);
        $display("test all_codes done");
        @(posedge clk) iso <= 1'b1;
        send(15, 5, 1, 0);
        @(posedge clk);
        lvalid <= 1'b1;
        lrep <= {4'h9, 9'h0AA, 1'b1};
        @(posedge clk);
        lvalid <= 1'b0;
        iso <= 1'b0;
        #1 model(9, 170, 1);
        `CHK(lw, {mperm[0], mcnt[1:0], mtype[3:0], mnode[8:0]})
        $display("test isolated done");
        @(posedge clk) rst_n <= 1'b0;
        @(posedge clk) rst_n <= 1'b1;
        #1 mcnt = 0;
        mperm = 0;
        `CHK(lw, {mperm[0], mcnt[1:0], mtype[3:0], mnode[8:0]})
        send(13, 7, 1, 1);
        $display("test reset_keeps_type done");
        report_and_stop();
    end
endmodule
`default_nettype wire
